/* File: logic/acs_consts.vh */
// Constants of the conversion sequencer: register indices, field positions,
// reset values and timing counts. Included by every design file.
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ACS_IDX_CTRL_A     4'h0
`define ACS_IDX_CTRL_B     4'h1
`define ACS_IDX_EVENT      4'h2
`define ACS_IDX_PRESCALE   4'h3
`define ACS_IDX_GAIN       4'h4
`define ACS_IDX_THRESHOLD  4'h5
`define ACS_IDX_CMP_MODE   4'h6
`define ACS_IDX_STATUS     4'h7
`define ACS_IDX_RESULT     4'h8
`define ACS_IDX_CALIB      4'h9

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACS_A_ENABLE       0
`define ACS_A_FLUSH        1
`define ACS_A_START        2
`define ACS_B_FMT_LO       1
`define ACS_B_CONTINUOUS   3
`define ACS_B_SIGN         4
`define ACS_B_CUR_LO       5
`define ACS_G_ENABLE       3
`define ACS_S_FLAG         0
`define ACS_S_BUSY         1

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define ACS_FMT_12R        2'h0
`define ACS_FMT_8R         2'h2
`define ACS_FMT_12L        2'h3
`define ACS_EV_NONE        3'h0
`define ACS_EV_START       3'h1
`define ACS_EV_SYNC_FLUSH  3'h6
`define ACS_CMP_DONE       2'h0
`define ACS_CMP_BELOW      2'h1
`define ACS_CMP_ABOVE      2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACS_RST_CTRL_A     8'h00
`define ACS_RST_CTRL_B     8'h00
`define ACS_RST_BYTE       8'h00
`define ACS_RST_THRESHOLD  12'h000

// ----------------------------------------------------------------
// Timing counts, in half conversion clock periods
// ----------------------------------------------------------------
// Whole measurement is 1 + (res+1)/2 cycles: 5 cycles at 8 bits, 7 at 12
`define ACS_HALVES_8       5'h0a
`define ACS_HALVES_12      5'h0e
`define ACS_BITS_8         5'h08
`define ACS_BITS_12        5'h0c

`endif

/* File: logic/acs_prescaler.v */
// Conversion clock generator: divides pclk by 4 << div_code.
// Assumes restart is a one-cycle pulse from the sequencer.
`include "acs_consts.vh"

module acs_prescaler (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Control
  input  wire       restart,
  input  wire [2:0] div_code,
  // Conversion clock and its phase marks
  output reg        conv_clk_reg,
  output wire       half_tick,
  output wire       cyc_start
);

  reg  [8:0] cnt_reg;
  reg        phase_reg;
  wire [8:0] half_lim;

  // Half period of 2 << div_code pclk cycles
  assign half_lim  = (9'h002 << div_code) - 9'h001;
  assign half_tick = (cnt_reg == 9'h000);
  assign cyc_start = half_tick & ~phase_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg      <= 9'h000;
      phase_reg    <= 1'b0;
      conv_clk_reg <= 1'b0;
    end else if (restart) begin
      // Next pclk cycle opens a fresh conversion clock cycle
      cnt_reg      <= 9'h000;
      phase_reg    <= 1'b0;
      conv_clk_reg <= 1'b1;
    end else if (cnt_reg >= half_lim) begin
      // Greater-or-equal: a smaller code written mid-count must not wrap the counter
      cnt_reg      <= 9'h000;
      phase_reg    <= ~phase_reg;
      conv_clk_reg <= phase_reg;
    end else begin
      cnt_reg      <= cnt_reg + 9'h001;
      conv_clk_reg <= ~phase_reg;
    end
  end

endmodule // acs_prescaler

/* File: logic/acs_result_fmt.v */
// Result formatter: places a raw code into the 16-bit result word.
// Assumes raw holds an 8-bit code in its low byte in 8-bit mode.
`include "acs_consts.vh"

module acs_result_fmt (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // Raw code and format
  input  wire        load,
  input  wire [11:0] raw,
  input  wire [1:0]  fmt,
  input  wire        sign_mode,
  // Formatted result
  output reg  [15:0] result_reg
);

  reg [15:0] result_next;

  always @* begin
    case (fmt)
      `ACS_FMT_8R:  result_next = {{8{sign_mode & raw[7]}}, raw[7:0]};
      `ACS_FMT_12L: result_next = {raw, 4'h0};
      // Reserved code behaves as 12-bit right adjusted
      default:      result_next = {{4{sign_mode & raw[11]}}, raw};
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= 16'h0000;
    end else if (load) begin
      result_reg <= result_next;
    end
  end

endmodule // acs_result_fmt

/* File: logic/acs_sequencer.v */
// Conversion sequencer of a successive-approximation converter, APB slave.
// Assumes an analog core that samples on sample_o and answers cmp_bit_in
// by the end of every half period marked by bit_strobe_o.
`include "acs_consts.vh"

module acs_sequencer (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_reg,
  output reg         pready_reg,
  output reg         pslverr_reg,
  // Event system and DMA
  input  wire        event_in,
  output reg         event_out_reg,
  output reg         dma_req_reg,
  output reg         irq_reg,
  // Analog core
  input  wire        cmp_bit_in,
  output wire        conv_clk_o,
  output reg         sample_reg,
  output reg         gain_stage_reg,
  output reg         bit_strobe_reg,
  output reg  [1:0]  cur_cap_reg,
  output reg  [7:0]  calib_reg
);

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  reg         state_reg;
  reg         state_next;
  reg  [4:0]  half_reg;
  reg  [4:0]  half_next;
  reg  [11:0] sar_reg;
  reg         enable_reg;
  reg         start_pend_reg;
  reg         again_reg;
  reg  [7:0]  ctrl_b_reg;
  reg  [2:0]  ev_action_reg;
  reg  [2:0]  div_code_reg;
  reg  [3:0]  gain_reg;
  reg  [11:0] threshold_reg;
  reg  [1:0]  cmp_mode_reg;
  reg         flag_reg;
  reg         hit_d_reg;

  wire        half_tick;
  wire        cyc_start;
  wire [15:0] result;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Greater-than on 12-bit codes, signed or unsigned
  function gt12;
    input [11:0] a;
    input [11:0] b;
    input        sgn;
    begin
      gt12 = sgn ? ($signed(a) > $signed(b)) : (a > b);
    end
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire       setup    = psel & ~penable;
  wire       wr_acc   = psel & penable & pready_reg & pwrite;
  wire [3:0] idx      = paddr[5:2];
  wire       mapped   = (paddr[11:6] == 6'h00) && (idx <= `ACS_IDX_CALIB);
  wire       wr_a     = wr_acc & mapped & (idx == `ACS_IDX_CTRL_A);

  // ----------------------------------------------------------------
  // Start, flush and event sources
  // ----------------------------------------------------------------
  wire res8      = (ctrl_b_reg[`ACS_B_FMT_LO+1:`ACS_B_FMT_LO] == `ACS_FMT_8R);
  wire sign_mode = ctrl_b_reg[`ACS_B_SIGN];
  wire cont_mode = ctrl_b_reg[`ACS_B_CONTINUOUS];
  wire [2:0] gain_x = gain_reg[`ACS_G_ENABLE] ? gain_reg[2:0] : 3'h0;

  wire ev_sync  = enable_reg & event_in & (ev_action_reg == `ACS_EV_SYNC_FLUSH);
  wire ev_start = enable_reg & event_in & (ev_action_reg == `ACS_EV_START);
  wire sw_start = wr_a & pwdata[`ACS_A_START] & enable_reg;
  wire sw_flush = wr_a & pwdata[`ACS_A_FLUSH];
  wire flush    = sw_flush | ev_sync;
  wire start_set = sw_start | ev_start | ev_sync;

  // Total half periods of one measurement
  wire [4:0] total   = (res8 ? `ACS_HALVES_8 : `ACS_HALVES_12) + {2'b00, gain_x};
  wire [4:0] nbits   = res8 ? `ACS_BITS_8 : `ACS_BITS_12;
  wire [4:0] bit_lo  = 5'h01 + {2'b00, gain_x};
  wire [4:0] bit_hi  = {2'b00, gain_x} + nbits;

  wire in_conv   = (state_reg == ST_CONV);
  wire complete  = in_conv & half_tick & (half_reg == total - 5'h01) & ~flush;
  wire bit_end   = in_conv & half_tick & (half_reg >= bit_lo) & (half_reg <= bit_hi);
  // Start only on a conversion cycle boundary; no gap after a completion unless an odd gain count ends it mid-cycle
  wire want      = start_pend_reg | again_reg | (complete & cont_mode);
  wire start_now = enable_reg & ~flush & cyc_start & (~in_conv | complete) & want;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    half_next  = half_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_now) begin
          state_next = ST_CONV;
          half_next  = 5'h00;
        end
      end
      ST_CONV: begin
        if (flush || !enable_reg) begin
          // Work in progress is dropped
          state_next = ST_IDLE;
          half_next  = 5'h00;
        end else if (start_now) begin
          half_next  = 5'h00;
        end else if (complete) begin
          state_next = ST_IDLE;
          half_next  = 5'h00;
        end else if (half_tick) begin
          half_next  = half_reg + 5'h01;
        end
      end
      default: begin
        state_next = ST_IDLE;
        half_next  = 5'h00;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= ST_IDLE;
      half_reg       <= 5'h00;
      sar_reg        <= 12'h000;
      sample_reg     <= 1'b0;
      gain_stage_reg <= 1'b0;
      bit_strobe_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      half_reg       <= half_next;
      sample_reg     <= (state_next == ST_CONV) && (half_next == 5'h00);
      gain_stage_reg <= (state_next == ST_CONV) && (half_next != 5'h00) && (half_next < bit_lo);
      bit_strobe_reg <= (state_next == ST_CONV) && (half_next >= bit_lo) && (half_next <= bit_hi);
      if (start_now) begin
        sar_reg <= 12'h000;
      end else if (bit_end) begin
        sar_reg <= {sar_reg[10:0], cmp_bit_in};
      end
    end
  end

  // ----------------------------------------------------------------
  // Start queue
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pend_reg <= 1'b0;
      again_reg      <= 1'b0;
    end else if (!enable_reg) begin
      start_pend_reg <= 1'b0;
      again_reg      <= 1'b0;
    end else begin
      // A new request in the cycle of a start stays pending; flush keeps the queue
      start_pend_reg <= start_set | (start_pend_reg & ~start_now);
      again_reg      <= cont_mode & ((complete & ~start_now) | (again_reg & ~start_now));
    end
  end

  // ----------------------------------------------------------------
  // Result, compare, flag, event and DMA
  // ----------------------------------------------------------------
  wire [11:0] cmp_val = res8 ? {{4{sign_mode & sar_reg[7]}}, sar_reg[7:0]} : sar_reg;
  reg         hit;

  always @* begin
    case (cmp_mode_reg)
      `ACS_CMP_BELOW: hit = gt12(threshold_reg, cmp_val, sign_mode);
      `ACS_CMP_ABOVE: hit = gt12(cmp_val, threshold_reg, sign_mode);
      default:        hit = 1'b1;
    endcase
  end

  acs_result_fmt u_fmt (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (complete),
    .raw        (sar_reg),
    .fmt        (ctrl_b_reg[`ACS_B_FMT_LO+1:`ACS_B_FMT_LO]),
    .sign_mode  (sign_mode),
    .result_reg (result)
  );

  wire flag_clr = wr_acc & mapped & (idx == `ACS_IDX_STATUS) & pwdata[`ACS_S_FLAG];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_d_reg     <= 1'b0;
      flag_reg      <= 1'b0;
      irq_reg       <= 1'b0;
      event_out_reg <= 1'b0;
      dma_req_reg   <= 1'b0;
    end else begin
      // Flag waits a cycle so the formatted result is readable first
      hit_d_reg     <= complete & hit;
      flag_reg      <= hit_d_reg | (flag_reg & ~flag_clr);
      irq_reg       <= hit_d_reg | (flag_reg & ~flag_clr);
      event_out_reg <= complete & hit;
      dma_req_reg   <= complete;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg    <= 1'b0;
      ctrl_b_reg    <= `ACS_RST_CTRL_B;
      ev_action_reg <= 3'h0;
      div_code_reg  <= 3'h0;
      gain_reg      <= 4'h0;
      threshold_reg <= `ACS_RST_THRESHOLD;
      cmp_mode_reg  <= 2'h0;
      cur_cap_reg   <= 2'h0;
      calib_reg     <= `ACS_RST_BYTE;
    end else if (wr_acc && mapped) begin
      case (idx)
        `ACS_IDX_CTRL_A:    enable_reg    <= pwdata[`ACS_A_ENABLE];
        `ACS_IDX_CTRL_B: begin
          ctrl_b_reg  <= pwdata[7:0] & 8'h7e;
          cur_cap_reg <= pwdata[`ACS_B_CUR_LO+1:`ACS_B_CUR_LO];
        end
        `ACS_IDX_EVENT:     ev_action_reg <= pwdata[2:0];
        `ACS_IDX_PRESCALE:  div_code_reg  <= pwdata[2:0];
        `ACS_IDX_GAIN:      gain_reg      <= pwdata[3:0];
        `ACS_IDX_THRESHOLD: threshold_reg <= pwdata[11:0];
        `ACS_IDX_CMP_MODE:  cmp_mode_reg  <= pwdata[1:0];
        `ACS_IDX_CALIB:     calib_reg     <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB read and response
  // ----------------------------------------------------------------
  reg [31:0] rd_data;

  always @* begin
    rd_data = 32'h00000000;
    case (idx)
      // Flush reads zero; bits 7:3 are reserved
      `ACS_IDX_CTRL_A:    rd_data = {29'h0, start_pend_reg, 1'b0, enable_reg};
      `ACS_IDX_CTRL_B:    rd_data = {24'h0, ctrl_b_reg};
      `ACS_IDX_EVENT:     rd_data = {29'h0, ev_action_reg};
      `ACS_IDX_PRESCALE:  rd_data = {29'h0, div_code_reg};
      `ACS_IDX_GAIN:      rd_data = {28'h0, gain_reg};
      `ACS_IDX_THRESHOLD: rd_data = {20'h0, threshold_reg};
      `ACS_IDX_CMP_MODE:  rd_data = {30'h0, cmp_mode_reg};
      `ACS_IDX_STATUS:    rd_data = {30'h0, in_conv, flag_reg};
      `ACS_IDX_RESULT:    rd_data = {16'h0, result};
      `ACS_IDX_CALIB:     rd_data = {24'h0, calib_reg};
      default:            rd_data = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      // One wait-free access phase after every setup cycle
      pready_reg  <= setup;
      pslverr_reg <= setup & ~mapped;
      prdata_reg  <= (setup & ~pwrite & mapped) ? rd_data : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  acs_prescaler u_presc (
    .pclk         (pclk),
    .presetn      (presetn),
    .restart      (flush),
    .div_code     (div_code_reg),
    .conv_clk_reg (conv_clk_o),
    .half_tick    (half_tick),
    .cyc_start    (cyc_start)
  );

endmodule // acs_sequencer

/* File: test/acs_seq_props.sv */
// Port assertions for the conversion sequencer.
// Assumes an APB master that holds each request until pready.
module acs_seq_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_reg,
  input wire logic        pready_reg,
  input wire logic        pslverr_reg,
  // Completion and analog strobes
  input wire logic        dma_req_reg,
  input wire logic        irq_reg,
  input wire logic        sample_reg,
  input wire logic        gain_stage_reg,
  input wire logic        bit_strobe_reg,
  input wire logic        event_out_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic en_q;
  wire  setup   = psel && !penable;
  wire  ctl_acc = psel && penable && pready_reg && paddr[11:2] == 10'h000;
  // ------------------------------------------
  // Enable copy, rebuilt from bus traffic
  // ------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) en_q <= 1'b0;
    else if (ctl_acc && pwrite) en_q <= pwdata[0];
  end
  a_ready_next: assert property (setup |=> pready_reg) else $error("no ready after setup");
  a_ready_once: assert property (pready_reg |=> !pready_reg) else $error("ready held too long");
  a_unmapped_err: assert property (setup && paddr[5:2] > 4'h9 |=> pslverr_reg && prdata_reg == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (setup && paddr[11:6] == 6'h00 && paddr[5:2] <= 4'h9 |=> !pslverr_reg)
    else $error("mapped access refused");
  a_reserved_zero: assert property (ctl_acc && !pwrite |-> prdata_reg[7:3] == 5'h00 && !prdata_reg[1])
    else $error("reserved or flush bit read nonzero");
  a_idle_disabled: assert property (!en_q && !$past(en_q) |=> !sample_reg && !bit_strobe_reg && !dma_req_reg)
    else $error("activity while disabled");
  a_dma_pulse: assert property (dma_req_reg |=> !dma_req_reg) else $error("dma request too long");
  a_flag_after: assert property (event_out_reg |=> irq_reg) else $error("flag missing after completion");
  a_flag_cause: assert property ($rose(irq_reg) |-> $past(event_out_reg)) else $error("flag without completion");
  a_sample_first: assert property ($rose(bit_strobe_reg) |-> $past(sample_reg) || $past(gain_stage_reg))
    else $error("bits resolved before sampling");
  c_sample: cover property ($rose(sample_reg));
  c_gain: cover property ($rose(gain_stage_reg));
  c_back_to_back: cover property (dma_req_reg ##20 dma_req_reg);
endmodule // acs_seq_props

bind acs_sequencer acs_seq_props u_acs_seq_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata_reg, .pready_reg, .pslverr_reg, .dma_req_reg, .irq_reg, .sample_reg, .gain_stage_reg, .bit_strobe_reg,
  .event_out_reg);

/* File: test/acs_core_model.sv */
// Behavioural comparator of the analog core.
// Assumes the bench tells it the half period and bit count in use.
module acs_core_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Strobe and set-up
  input  wire logic        bit_strobe_reg,
  input  wire logic [7:0]  half_len,
  input  wire logic [4:0]  nbits,
  input  wire logic [11:0] target,
  // Comparator decision
  output logic             cmp_bit_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt;
  int   pos;
  logic tgl;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      tgl <= 1'b0;
    end else begin
      cnt <= bit_strobe_reg ? cnt + 1 : 0;
      tgl <= !tgl;
    end
  end
  // Outside bit halves the line keeps moving, so stale decisions never pass
  always @* begin
    pos = int'(nbits) - 1 - cnt / int'(half_len);
    if (bit_strobe_reg && pos >= 0) cmp_bit_in = target[pos];
    else cmp_bit_in = tgl;
  end
endmodule // acs_core_model

/* File: test/acs_sequencer_tb_top.sv */
// Self-checking bench for the conversion sequencer.
// Assumes the analog core model and the bound port checker.
module acs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        event_in = 1'b0;
  logic [7:0]  half_len = 8'h02;
  logic [4:0]  nbits = 5'h08;
  logic [11:0] target = 12'h0b7;
  logic        smp_q = 1'b0;
  logic        cc_q = 1'b0;
  logic        err_q;
  wire  [31:0] prdata_reg;
  wire         pready_reg, pslverr_reg, event_out_reg, dma_req_reg, irq_reg, cmp_bit_in, conv_clk_o;
  wire         sample_reg, gain_stage_reg, bit_strobe_reg;
  wire  [1:0]  cur_cap_reg;
  wire  [7:0]  calib_reg;
  int          fail_count = 0, compares = 0, cyc = 0, last = 0, gap = 0, t_smp = 0, span = 0;
  int          smp_n = 0, bit_n = 0, gn_n = 0, dma_n = 0, ev_n = 0, crise = 0, cper = 0;
  logic [7:0]  rb [7] = '{8'h04, 8'h00, 8'h10, 8'h06, 8'h02, 8'h00, 8'h04};
  logic [7:0]  rg [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0b, 8'h00};
  logic [11:0] rt [7] = '{12'h0b7, 12'ha5c, 12'ha5c, 12'ha5c, 12'ha5c, 12'ha5c, 12'h0b7};
  logic [15:0] rr [7] = '{16'h00b7, 16'h0a5c, 16'hfa5c, 16'ha5c0, 16'h0a5c, 16'h0a5c, 16'h00b7};

  always #5 pclk = ~pclk;

  acs_sequencer u_acs_sequencer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_reg,
    .pready_reg, .pslverr_reg, .event_in, .event_out_reg, .dma_req_reg, .irq_reg, .cmp_bit_in, .conv_clk_o,
    .sample_reg, .gain_stage_reg, .bit_strobe_reg, .cur_cap_reg, .calib_reg);
  acs_core_model u_acs_core_model (.pclk, .presetn, .bit_strobe_reg, .half_len, .nbits, .target, .cmp_bit_in);

  // ------------------------------------------
  // Monitor and hang guard
  // ------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    smp_q <= sample_reg;
    cc_q <= conv_clk_o;
    if (conv_clk_o && !cc_q) begin
      cper <= cyc - crise;
      crise <= cyc;
    end
    if (sample_reg && !smp_q) t_smp <= cyc;
    if (sample_reg) smp_n <= smp_n + 1;
    if (bit_strobe_reg) bit_n <= bit_n + 1;
    if (gain_stage_reg) gn_n <= gn_n + 1;
    if (event_out_reg) ev_n <= ev_n + 1;
    if (dma_req_reg) begin
      dma_n <= dma_n + 1;
      gap <= cyc - last;
      last <= cyc;
      span <= cyc - t_smp;
    end
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  // Idle cycle after each transfer keeps psel from being driven twice in one step
  task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {6'h00, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No limit of its own: the cycle ceiling ends a hang
    do begin
      @(posedge pclk);
    end while (pready_reg !== 1'b1);
    r = prdata_reg;
    err_q = pslverr_reg;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic clr;
    smp_n <= 0;
    bit_n <= 0;
    gn_n <= 0;
    dma_n <= 0;
    ev_n <= 0;
  endtask

  task automatic wait_dma(input int n);
    int k;
    k = 0;
    while (dma_n < n && k < 600) begin
      @(posedge pclk);
      k++;
    end
    check(dma_n, n, "completion count");
  endtask

  initial begin
    logic [31:0] d;
    int h, nb, ng;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, i[3:0], 32'h0, d);
      check(d, 32'h0, "reset value");
    end
    bus(1'b0, 4'ha, 32'h0, d);
    check(err_q, 32'h1, "unmapped error");
    wr(4'h0, 32'h1);
    bus(1'b0, 4'h0, 32'h0, d);
    check(d, 32'h1, "control a readback");
    wr(4'h1, 32'hff);
    bus(1'b0, 4'h1, 32'h0, d);
    check(d, 32'h7e, "control b readback");
    check(cur_cap_reg, 32'h3, "current cap copy");
    wr(4'h9, 32'h5a);
    check(calib_reg, 32'h5a, "calibration byte");
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      h = (i == 6) ? 4 : 2;
      nb = (rb[i][2:1] == 2'h2) ? 8 : 12;
      ng = rg[i][3] ? int'(rg[i][2:0]) : 0;
      half_len <= h[7:0];
      nbits <= nb[4:0];
      target <= rt[i];
      wr(4'h3, (i == 6) ? 32'h1 : 32'h0);
      wr(4'h4, {24'h0, rg[i]});
      wr(4'h1, {24'h0, rb[i]});
      clr;
      wr(4'h0, 32'h5);
      wait_dma(1);
      repeat (2) @(posedge pclk);
      bus(1'b0, 4'h8, 32'h0, d);
      check(d, {16'h0, rr[i]}, "result word");
      check(smp_n, h, "sample length");
      check(bit_n, nb * h, "bit halves");
      check(gn_n, ng * h, "gain halves");
      check(ev_n, 1, "completion event");
      check(cper, 2 * h, "conversion clock period");
      check(span, (2 * (1 + (nb + 1) / 2) + ng) * h, "conversion time");
      bus(1'b0, 4'h7, 32'h0, d);
      check(d[0], 32'h1, "flag set");
      wr(4'h7, 32'h1);
    end
    $display("test conversions done");
    half_len <= 8'h02;
    nbits <= 5'h08;
    target <= 12'h0b7;
    wr(4'h3, 32'h0);
    wr(4'h4, 32'h0);
    wr(4'h5, 32'h100);
    for (int m = 1; m < 3; m++) begin
      wr(4'h6, m);
      clr;
      wr(4'h0, 32'h5);
      wait_dma(1);
      repeat (3) @(posedge pclk);
      check(ev_n, (m == 1) ? 1 : 0, "threshold event");
    end
    $display("test compare done");
    clr;
    wr(4'h0, 32'h5);
    while (bit_strobe_reg !== 1'b1 && cyc < 19000) @(posedge pclk);
    wr(4'h0, 32'h5);
    bus(1'b0, 4'h0, 32'h0, d);
    check(d[2], 32'h1, "start pending");
    wr(4'h0, 32'h3);
    repeat (80) @(posedge pclk);
    check(dma_n, 1, "flush keeps queue");
    bus(1'b0, 4'h0, 32'h0, d);
    check(d[2], 32'h0, "start cleared");
    $display("test flush done");
    for (int e = 1; e < 7; e += 5) begin
      wr(4'h2, e);
      clr;
      wr(4'h0, 32'h5);
      repeat (6) @(posedge pclk);
      event_in <= 1'b1;
      @(posedge pclk);
      event_in <= 1'b0;
      repeat (90) @(posedge pclk);
      check(dma_n, (e == 6) ? 1 : 2, "event start");
    end
    $display("test events done");
    clr;
    wr(4'h1, 32'h0c);
    wr(4'h0, 32'h5);
    wait_dma(2);
    check(gap, 20, "back to back gap");
    wr(4'h0, 32'h0);
    wr(4'h2, 32'h1);
    clr;
    event_in <= 1'b1;
    @(posedge pclk);
    event_in <= 1'b0;
    wr(4'h0, 32'h4);
    repeat (60) @(posedge pclk);
    check(dma_n, 0, "disabled idle");
    bus(1'b0, 4'h0, 32'h0, d);
    check(d, 32'h0, "start ignored");
    $display("test disable done");
    tally_and_finish;
  end
endmodule // acs_sequencer_tb_top
